// ### hw/ipi_pkg.sv
// Purpose: constants and types for the input pattern interrupt block
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: register map, field positions and reset values live here
package ipi_pkg;

    localparam int NSLOT = 4;
    localparam int NTHR = 4;
    localparam int NIN = 32;
    localparam int NIN_REDUCED = 16;
    localparam int AW = 8;
    localparam int DW = 32;

    // per-slot registers at slot * SLOT_STRIDE + field offset, from address 0
    localparam logic [7:0] SLOT_STRIDE = 8'h10;
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_SEL = 8'h04;
    localparam logic [7:0] OFS_POL = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h40;
    localparam logic [7:0] ADDR_STATUS = 8'h44;
    localparam logic [7:0] ADDR_CLEAR = 8'h48;
    localparam logic [7:0] ADDR_ENABLE = 8'h4c;
    localparam logic [7:0] ADDR_STATE = 8'h50;

    // config, control and state word fields
    localparam int CFG_THREAD_LSB = 0;
    localparam int CFG_COMBINE_BIT = 4;
    localparam int CTRL_REDUCED_BIT = 0;
    localparam int STATE_BUSY_LSB = 4;
    localparam int STATE_HIT_LSB = 8;

    localparam logic [2:0] THREAD_OFF = 3'h7;
    localparam logic COMBINE_AND = 1'b0;
    localparam logic COMBINE_OR = 1'b1;
    localparam logic [NIN-1:0] SEL_RST = 32'h0000_0000;
    localparam logic [NIN-1:0] POL_RST = 32'h0000_0000;
    localparam logic [NSLOT-1:0] ARMED_RST = 4'hf;
    localparam logic [NIN-1:0] REDUCED_MASK = 32'h0000_ffff;

    typedef struct packed {
        logic combine;
        logic [2:0] thread;
        logic [NIN-1:0] sel;
        logic [NIN-1:0] pol;
    } ipi_slot_cfg_t;

    localparam ipi_slot_cfg_t SLOT_CFG_RST = '{combine: COMBINE_AND, thread: THREAD_OFF, sel: SEL_RST, pol: POL_RST};

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic wr;
        logic rd;
    } ipi_bus_req_t;

endpackage

// ### hw/ipi_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs asynchronous to clk_sys
// Notes: a change is taken once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ipi_sync #(
    parameter int W = 32
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_q
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // stage one feeds stage two only
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    s1_q[i] <= 1'b0;
                    s2_q[i] <= 1'b0;
                    s3_q[i] <= 1'b0;
                    level_q[i] <= 1'b0;
                end else begin
                    s1_q[i] <= pin_in[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                    if (s2_q[i] == s3_q[i]) begin
                        level_q[i] <= s3_q[i];
                    end
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ### hw/ipi_top.sv
// Purpose: input pattern interrupt controller, four slots onto four threads
// Assumes: thread status inputs come from logic on clk_sys; input pins are asynchronous
// Notes: registers reached over a plain strobe port, read data one cycle later
`timescale 1ns/1ps
`default_nettype none
module ipi_top (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [ipi_pkg::AW-1:0] reg_addr,
    input wire logic [ipi_pkg::DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [ipi_pkg::DW-1:0] reg_rdata,
    input wire logic [ipi_pkg::NIN-1:0] din,
    input wire logic program_running,
    input wire logic [ipi_pkg::NTHR-1:0] thread_running,
    input wire logic [ipi_pkg::NTHR-1:0] trip_pending,
    input wire logic interrupt_return,
    input wire logic [1:0] interrupt_return_thread,
    input wire logic [ipi_pkg::NTHR-1:0] call_stack_clear,
    output logic [ipi_pkg::NTHR-1:0] input_service_routine,
    output logic [2*ipi_pkg::NTHR-1:0] service_slot,
    output logic [ipi_pkg::NTHR-1:0] thread_hold,
    output logic [ipi_pkg::NTHR-1:0] trip_clear,
    output logic [ipi_pkg::NTHR-1:0] trip_restore,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    ipi_pkg::ipi_bus_req_t req;
    ipi_pkg::ipi_slot_cfg_t cfg_q [ipi_pkg::NSLOT];
    logic [ipi_pkg::NIN-1:0] din_lvl;
    logic reduced_q;
    logic [ipi_pkg::NSLOT-1:0] armed_q;
    logic [ipi_pkg::NSLOT-1:0] hit_q;
    logic [ipi_pkg::NSLOT-1:0] cond;
    logic [ipi_pkg::NSLOT-1:0] slot_on;
    logic [ipi_pkg::NSLOT-1:0] cfg_wr;
    logic [ipi_pkg::NSLOT-1:0] fire_d;
    logic [ipi_pkg::NSLOT-1:0] drop_d;
    logic [ipi_pkg::NSLOT-1:0] rearm_d;
    logic [ipi_pkg::NTHR-1:0] claim_d;
    logic [ipi_pkg::NTHR-1:0] busy_q;
    logic [ipi_pkg::NTHR-1:0] saved_trip_q;
    logic [1:0] busy_slot_q [ipi_pkg::NTHR];
    logic [ipi_pkg::NTHR-1:0] ret_d;
    logic [ipi_pkg::NTHR-1:0] abandon_d;
    logic [ipi_pkg::NSLOT-1:0] status_q;
    logic [ipi_pkg::NSLOT-1:0] enable_q;
    logic [ipi_pkg::NSLOT-1:0] clear_d;
    logic [ipi_pkg::NIN-1:0] usable;
    logic [ipi_pkg::DW-1:0] rdata_d;
    logic [ipi_pkg::NTHR-1:0] isr_q;
    logic [ipi_pkg::NTHR-1:0] tclr_q;
    logic [ipi_pkg::NTHR-1:0] trst_q;
    logic [2*ipi_pkg::NTHR-1:0] sslot_q;
    logic irq_q;
    logic [ipi_pkg::DW-1:0] rdata_q;

    assign req.addr = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.wr = reg_wr;
    assign req.rd = reg_rd;

    ////////////////////////////////////////////////////////////////////////////
    // input pins

    ipi_sync #(
        .W(ipi_pkg::NIN)
    ) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pin_in(din),
        .level_q(din_lvl)
    );

    // upper inputs cannot be selected on the reduced variant
    assign usable = reduced_q ? ipi_pkg::REDUCED_MASK : '1;

    ////////////////////////////////////////////////////////////////////////////
    // per-slot configuration and pattern evaluation

    genvar s;
    generate
        for (s = 0; s < ipi_pkg::NSLOT; s++) begin : g_slot
            logic [ipi_pkg::NIN-1:0] sel_eff;
            logic [ipi_pkg::NIN-1:0] match;

            assign cfg_wr[s] = req.wr && (req.addr == 8'(s * ipi_pkg::SLOT_STRIDE) + ipi_pkg::OFS_CFG);

            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    cfg_q[s] <= ipi_pkg::SLOT_CFG_RST;
                end else if (req.wr) begin
                    if (cfg_wr[s]) begin
                        cfg_q[s].thread <= req.wdata[ipi_pkg::CFG_THREAD_LSB +: 3];
                        cfg_q[s].combine <= req.wdata[ipi_pkg::CFG_COMBINE_BIT];
                    end
                    if (req.addr == 8'(s * ipi_pkg::SLOT_STRIDE) + ipi_pkg::OFS_SEL) begin
                        cfg_q[s].sel <= req.wdata;
                    end
                    if (req.addr == 8'(s * ipi_pkg::SLOT_STRIDE) + ipi_pkg::OFS_POL) begin
                        cfg_q[s].pol <= req.wdata;
                    end
                end
            end

            // thread values 4..7 (including -1) switch the slot off
            assign slot_on[s] = (cfg_q[s].thread[2] == 1'b0);

            assign sel_eff = cfg_q[s].sel & usable;
            assign match = ~(din_lvl ^ cfg_q[s].pol) & sel_eff;

            // an empty selection never fires, even under AND
            always_comb begin
                if (sel_eff == '0) begin
                    cond[s] = 1'b0;
                end else if (cfg_q[s].combine == ipi_pkg::COMBINE_OR) begin
                    cond[s] = |match;
                end else begin
                    cond[s] = (match == sel_eff);
                end
            end

            // latched hit survives a condition that lasts one cycle
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    hit_q[s] <= 1'b0;
                end else if (cfg_wr[s] || fire_d[s] || drop_d[s]) begin
                    hit_q[s] <= 1'b0;
                end else if (armed_q[s] && slot_on[s] && cond[s] && program_running) begin
                    hit_q[s] <= 1'b1;
                end
            end

            // armed clears on firing; a return or a write of the slot's config word re-arms
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    armed_q[s] <= ipi_pkg::ARMED_RST[s];
                end else if (fire_d[s]) begin
                    armed_q[s] <= 1'b0;
                end else if (rearm_d[s] || cfg_wr[s]) begin
                    armed_q[s] <= 1'b1;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // dispatch: lowest slot wins a thread, others wait for it to free up
    // a hit refused for a stopped thread is dropped, not retried;
    // the slot stays armed, so a lasting condition fires once the thread runs

    always_comb begin
        fire_d = '0;
        drop_d = '0;
        claim_d = '0;
        for (int i = 0; i < ipi_pkg::NSLOT; i++) begin
            if (hit_q[i]) begin
                if (!program_running || !slot_on[i] || !thread_running[cfg_q[i].thread[1:0]]) begin
                    drop_d[i] = 1'b1;
                end else if (!busy_q[cfg_q[i].thread[1:0]] && !claim_d[cfg_q[i].thread[1:0]]) begin
                    fire_d[i] = 1'b1;
                    claim_d[cfg_q[i].thread[1:0]] = 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // return and stack clear decoding
    // the thread code is only looked at beside the return pulse

    always_comb begin
        ret_d = '0;
        abandon_d = '0;
        rearm_d = '0;
        for (int t = 0; t < ipi_pkg::NTHR; t++) begin
            // a stack clear abandons the context and leaves the slot disarmed
            abandon_d[t] = call_stack_clear[t] && busy_q[t];
            if (interrupt_return && (interrupt_return_thread == 2'(t)) && busy_q[t] && !call_stack_clear[t]) begin
                ret_d[t] = 1'b1;
                rearm_d[busy_slot_q[t]] = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-thread service state

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            busy_q <= '0;
            saved_trip_q <= '0;
            for (int t = 0; t < ipi_pkg::NTHR; t++) begin
                busy_slot_q[t] <= 2'h0;
            end
        end else begin
            for (int t = 0; t < ipi_pkg::NTHR; t++) begin
                if (ret_d[t] || abandon_d[t]) begin
                    busy_q[t] <= 1'b0;
                    saved_trip_q[t] <= 1'b0;
                end else if (claim_d[t]) begin
                    busy_q[t] <= 1'b1;
                    saved_trip_q[t] <= trip_pending[t];
                    for (int i = 0; i < ipi_pkg::NSLOT; i++) begin
                        if (fire_d[i] && (cfg_q[i].thread[1:0] == 2'(t))) begin
                            busy_slot_q[t] <= 2'(i);
                        end
                    end
                end
            end
        end
    end

    // thread-facing strobes, all registered
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            isr_q <= '0;
            tclr_q <= '0;
            trst_q <= '0;
        end else begin
            isr_q <= claim_d;
            tclr_q <= claim_d & trip_pending;
            trst_q <= ret_d & saved_trip_q;
        end
    end

    always_comb begin
        for (int t = 0; t < ipi_pkg::NTHR; t++) begin
            sslot_q[2*t +: 2] = busy_slot_q[t];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status, enable and output

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            status_q <= '0;
        end else begin
            // a new firing wins over a clear in the same cycle
            status_q <= (status_q & ~clear_d) | fire_d;
        end
    end

    assign clear_d = (req.wr && req.addr == ipi_pkg::ADDR_CLEAR) ? req.wdata[ipi_pkg::NSLOT-1:0] : '0;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            enable_q <= '0;
            reduced_q <= 1'b0;
        end else if (req.wr) begin
            if (req.addr == ipi_pkg::ADDR_ENABLE) begin
                enable_q <= req.wdata[ipi_pkg::NSLOT-1:0];
            end
            if (req.addr == ipi_pkg::ADDR_CTRL) begin
                reduced_q <= req.wdata[ipi_pkg::CTRL_REDUCED_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            // one cycle behind status to keep the output registered
            irq_q <= |(status_q & enable_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read

    always_comb begin
        rdata_d = '0;
        for (int i = 0; i < ipi_pkg::NSLOT; i++) begin
            if (req.addr == 8'(i * ipi_pkg::SLOT_STRIDE) + ipi_pkg::OFS_CFG) begin
                rdata_d[ipi_pkg::CFG_THREAD_LSB +: 3] = cfg_q[i].thread;
                rdata_d[ipi_pkg::CFG_COMBINE_BIT] = cfg_q[i].combine;
            end
            if (req.addr == 8'(i * ipi_pkg::SLOT_STRIDE) + ipi_pkg::OFS_SEL) begin
                rdata_d = cfg_q[i].sel;
            end
            if (req.addr == 8'(i * ipi_pkg::SLOT_STRIDE) + ipi_pkg::OFS_POL) begin
                rdata_d = cfg_q[i].pol;
            end
        end
        case (req.addr)
            ipi_pkg::ADDR_CTRL: begin
                rdata_d[ipi_pkg::CTRL_REDUCED_BIT] = reduced_q;
            end
            ipi_pkg::ADDR_STATUS: begin
                rdata_d[ipi_pkg::NSLOT-1:0] = status_q;
            end
            ipi_pkg::ADDR_ENABLE: begin
                rdata_d[ipi_pkg::NSLOT-1:0] = enable_q;
            end
            ipi_pkg::ADDR_STATE: begin
                rdata_d[ipi_pkg::NSLOT-1:0] = armed_q;
                rdata_d[ipi_pkg::STATE_BUSY_LSB +: ipi_pkg::NTHR] = busy_q;
                rdata_d[ipi_pkg::STATE_HIT_LSB +: ipi_pkg::NSLOT] = hit_q;
            end
            default: begin
            end
        endcase
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rdata_q <= '0;
        end else if (req.rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata = rdata_q;
    assign input_service_routine = isr_q;
    assign trip_clear = tclr_q;
    assign trip_restore = trst_q;
    assign thread_hold = busy_q;
    assign irq = irq_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            service_slot <= '0;
        end else begin
            service_slot <= sslot_q;
        end
    end

endmodule
`default_nettype wire

// ### test/ipi_top_props.sv
// Purpose: port checker for ipi_top
// Assumes: one clk_sys domain, sys_rst synchronous
// Notes: thread 0 watched in depth, the others share its logic
`timescale 1ns/1ps
`default_nettype none
module ipi_top_props (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic program_running,
    input wire logic [ipi_pkg::NTHR-1:0] thread_running,
    input wire logic interrupt_return,
    input wire logic [1:0] interrupt_return_thread,
    input wire logic [ipi_pkg::NTHR-1:0] call_stack_clear,
    input wire logic [ipi_pkg::NTHR-1:0] input_service_routine,
    input wire logic [ipi_pkg::NTHR-1:0] thread_hold,
    input wire logic [ipi_pkg::NTHR-1:0] trip_clear,
    input wire logic [ipi_pkg::NTHR-1:0] trip_restore
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    wire logic ret0;
    logic ret_ok_q;
    assign ret0 = interrupt_return && interrupt_return_thread == 2'h0;
    // a return only counts while the thread is held and not abandoned
    always_ff @(posedge clk_sys) begin
        ret_ok_q <= !sys_rst && ret0 && thread_hold[0] && !call_stack_clear[0];
    end
    ////////////////////////////////////////////////////////////////////
    property p_start; $rose(thread_hold[0]) |-> input_service_routine[0]; endproperty
    a_start: assert property (p_start) else $error("hold rose without start");
    property p_run; input_service_routine[0] |-> $past(thread_running[0]); endproperty
    a_run: assert property (p_run) else $error("start on idle thread");
    property p_prog; |input_service_routine |-> $past(program_running); endproperty
    a_prog: assert property (p_prog) else $error("start without program");
    property p_trip; trip_clear[0] |-> input_service_routine[0] && thread_hold[0]; endproperty
    a_trip: assert property (p_trip) else $error("stray wait clear");
    property p_held;
        thread_hold[0] && !ret0 && !call_stack_clear[0] |=> thread_hold[0] && !input_service_routine[0];
    endproperty
    a_held: assert property (p_held) else $error("held thread restarted");
    property p_ret; ret_ok_q |-> !thread_hold[0]; endproperty
    a_ret: assert property (p_ret) else $error("return did not resume");
    property p_rest; trip_restore[0] |-> ret_ok_q; endproperty
    a_rest: assert property (p_rest) else $error("restore without return");
    property p_abandon;
        call_stack_clear[0] && thread_hold[0] |=> !thread_hold[0] && !trip_restore[0];
    endproperty
    a_abandon: assert property (p_abandon) else $error("stack clear mishandled");
    c_start: cover property (input_service_routine[0]);
    c_rest: cover property (trip_restore[0]);
    c_abandon: cover property (call_stack_clear[0] && thread_hold[0]);
endmodule
bind ipi_top ipi_top_props u_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .program_running(program_running),
    .thread_running(thread_running), .interrupt_return(interrupt_return),
    .interrupt_return_thread(interrupt_return_thread), .call_stack_clear(call_stack_clear),
    .input_service_routine(input_service_routine), .thread_hold(thread_hold), .trip_clear(trip_clear),
    .trip_restore(trip_restore));
`default_nettype wire

// ### test/ipi_thread_model.sv
// Purpose: behavioural model of the program threads
// Assumes: one routine served at a time
// Notes: return comes RET_DLY + 1 cycles after start while ret_en is high
`timescale 1ns/1ps
`default_nettype none
module ipi_thread_model (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ret_en,
    input wire logic [3:0] trip_set,
    input wire logic [3:0] input_service_routine,
    input wire logic [3:0] trip_clear,
    input wire logic [3:0] trip_restore,
    output logic [3:0] trip_pending,
    output logic interrupt_return,
    output logic [1:0] interrupt_return_thread
);
    localparam logic [5:0] RET_DLY = 6'h3c;
    logic [5:0] cnt_q;
    logic busy_q;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            trip_pending <= 4'h0;
            interrupt_return <= 1'b0;
            interrupt_return_thread <= 2'h0;
            cnt_q <= 6'h0;
            busy_q <= 1'b0;
        end else begin
            trip_pending <= ((trip_pending | trip_set) & ~trip_clear) | trip_restore;
            interrupt_return <= 1'b0;
            if (input_service_routine != 4'h0) begin
                busy_q <= 1'b1;
                cnt_q <= RET_DLY;
                for (int t = 0; t < 4; t++) begin
                    if (input_service_routine[t]) interrupt_return_thread <= 2'(t);
                end
            end else if (busy_q && ret_en) begin
                cnt_q <= cnt_q - 6'h1;
                if (cnt_q == 6'h0) begin
                    interrupt_return <= 1'b1;
                    busy_q <= 1'b0;
                end
            end else if (!busy_q) begin
                // thread code only valid with the pulse
                interrupt_return_thread <= interrupt_return_thread + 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ### test/test_input_pattern_interrupt.sv
// Purpose: directed bench for ipi_top
// Assumes: thread model returns after a fixed delay
// Notes: slots are switched off after each test but the last to keep them apart
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
    $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module test_input_pattern_interrupt;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] din = 32'h0;
    logic program_running = 1'b1;
    logic [3:0] thread_running = 4'hf;
    logic [3:0] call_stack_clear = 4'h0;
    logic [3:0] trip_set = 4'h0;
    logic ret_en = 1'b1;
    logic [31:0] reg_rdata;
    logic [3:0] trip_pending, input_service_routine, thread_hold, trip_clear, trip_restore;
    logic [7:0] service_slot;
    logic interrupt_return, irq;
    logic [1:0] interrupt_return_thread;
    int fail_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    always #5 clk_sys = ~clk_sys;
    ipi_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .din(din), .program_running(program_running),
        .thread_running(thread_running), .trip_pending(trip_pending), .interrupt_return(interrupt_return),
        .interrupt_return_thread(interrupt_return_thread), .call_stack_clear(call_stack_clear),
        .input_service_routine(input_service_routine), .service_slot(service_slot),
        .thread_hold(thread_hold), .trip_clear(trip_clear), .trip_restore(trip_restore), .irq(irq));
    ipi_thread_model u_thr (.clk_sys(clk_sys), .sys_rst(sys_rst), .ret_en(ret_en), .trip_set(trip_set),
        .input_service_routine(input_service_routine), .trip_clear(trip_clear), .trip_restore(trip_restore),
        .trip_pending(trip_pending), .interrupt_return(interrupt_return),
        .interrupt_return_thread(interrupt_return_thread));
    ////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ceiling well above the roughly 600 cycles the tests need
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            $display("unexpected at %0t: timeout", $time);
            tally_and_finish();
        end
    end
    // a gap cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input logic ei);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
        `CHK(irq, ei)
        @(posedge clk_sys);
    endtask
    task automatic setup(input logic [1:0] s, input logic [31:0] c, input logic [31:0] m, input logic [31:0] p);
        wr({2'b00, s, 4'h4}, m);
        wr({2'b00, s, 4'h8}, p);
        wr({2'b00, s, 4'h0}, c);
    endtask
    task automatic fire(input int t, input logic e, input logic [1:0] s, input logic tc, input int n);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < n && !hit; i++) begin
            @(negedge clk_sys);
            hit = input_service_routine[t];
        end
        `CHK(hit, e)
        if (hit) begin
            `CHK(trip_clear[t], tc)
            `CHK(thread_hold[t], 1'b1)
            @(negedge clk_sys);
            `CHK(service_slot[2*t +: 2], s)
        end
        @(posedge clk_sys);
    endtask
    task automatic wait_free;
        for (int i = 0; i < 90 && thread_hold !== 4'h0; i++) @(negedge clk_sys);
        `CHK(thread_hold, 4'h0)
        @(posedge clk_sys);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        chk_rd(8'h00, 32'h7, 1'b0);
        chk_rd(8'h50, 32'hf, 1'b0);
        chk_rd(8'h60, 32'h0, 1'b0);
        $display("test reset done");
        trip_set <= 4'h1;
        wr(8'h4c, 32'h1);
        trip_set <= 4'h0;
        setup(2'd0, 32'h0, 32'he, 32'h6);
        din <= 32'h2;
        fire(0, 1'b0, 2'h0, 1'b0, 16);
        din <= 32'h6;
        fire(0, 1'b1, 2'h0, 1'b1, 16);
        chk_rd(8'h44, 32'h1, 1'b1);
        wr(8'h48, 32'h1);
        chk_rd(8'h44, 32'h0, 1'b0);
        fire(0, 1'b0, 2'h0, 1'b0, 20);
        fire(0, 1'b1, 2'h0, 1'b1, 60);
        din <= 32'h20;
        wait_free;
        wr(8'h00, 32'h7);
        $display("test and done");
        setup(2'd1, 32'h11, 32'h30, 32'h10);
        fire(1, 1'b0, 2'h1, 1'b0, 16);
        din <= 32'h30;
        fire(1, 1'b1, 2'h1, 1'b0, 16);
        din <= 32'h20;
        wait_free;
        wr(8'h10, 32'h7);
        $display("test or done");
        ret_en <= 1'b0;
        thread_running <= 4'he;
        din <= 32'h1;
        setup(2'd2, 32'h0, 32'h1, 32'h1);
        fire(0, 1'b0, 2'h2, 1'b0, 16);
        thread_running <= 4'hf;
        fire(0, 1'b1, 2'h2, 1'b1, 16);
        call_stack_clear <= 4'h1;
        @(posedge clk_sys);
        call_stack_clear <= 4'h0;
        fire(0, 1'b0, 2'h2, 1'b0, 20);
        wr(8'h20, 32'h0);
        fire(0, 1'b1, 2'h2, 1'b0, 16);
        ret_en <= 1'b1;
        din <= 32'h0;
        wait_free;
        wr(8'h20, 32'h7);
        $display("test thread done");
        program_running <= 1'b0;
        din <= 32'h0;
        setup(2'd3, 32'h3, 32'h100, 32'h0);
        fire(3, 1'b0, 2'h3, 1'b0, 16);
        program_running <= 1'b1;
        fire(3, 1'b1, 2'h3, 1'b0, 16);
        din <= 32'h100;
        wait_free;
        wr(8'h30, 32'h7);
        $display("test program done");
        wr(8'h40, 32'h1);
        din <= 32'h1_0000;
        setup(2'd0, 32'h0, 32'h1_0000, 32'h1_0000);
        fire(0, 1'b0, 2'h0, 1'b0, 16);
        wr(8'h40, 32'h0);
        fire(0, 1'b1, 2'h0, 1'b0, 16);
        wait_free;
        $display("test reduced done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
